// ===== dic_channel.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// [R1] normal mode forwards conditioned field value
// [R2] simulation mode replaces field input entirely; the code replaces value and invalid but pv.fault still follows the line fault
// [R3] current-value strategy passes field value on fault
// [R4] substitute strategy outputs fallback bit on fault
// [R5] fallback value carries invalid status
// [R6] hold strategy freezes last valid value
// [R7] inversion flips the input bit
// [R8] monitored line fault flagged in status
// [R9] monitored line fault invokes error strategy
// [R10] on-delay in ms suppresses short highs
// [R11] channel active follows module active only
// [R12] off-delay in ms suppresses short lows
// [R13] fallback value is one configurable bit
// [R14] simulation gives configured bit and status
// [R15] invert, filter, strategy, then simulation override
module dic_channel #(
  parameter int unsigned P_CYC_PER_MS = dic_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  // field side and module setting
  input  wire logic                       field_in,
  input  wire logic                       line_fault_in,
  input  wire logic                       module_active,
  // com unit side
  output dic_pkg::dic_pv_s                pv,
  output logic                            irq,
  // axi4-lite write address
  input  wire logic [dic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read address
  input  wire logic [dic_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  localparam logic [dic_pkg::CYC_W-1:0] CYC_LAST =
    dic_pkg::CYC_W'(P_CYC_PER_MS - 1);

  // ********************************************************
  // declarations
  // ********************************************************
  logic [1:0]                      sync1;
  logic [1:0]                      sync2;
  logic [1:0]                      sync3;
  logic [1:0]                      pin;
  logic                            cond_in;
  logic                            fault;
  logic                            filt;
  logic [dic_pkg::CYC_W-1:0]       cyc;
  logic [dic_pkg::DLY_W-1:0]       ms;
  logic [dic_pkg::DLY_W-1:0]       dly;
  logic                            hold_val;
  logic                            next_value;
  logic                            next_invalid;
  dic_pkg::dic_cfg_s               cfg;
  logic [dic_pkg::DLY_W-1:0]       on_dly;
  logic [dic_pkg::DLY_W-1:0]       off_dly;
  logic [dic_pkg::IRQ_W-1:0]       irq_sts;
  logic [dic_pkg::IRQ_W-1:0]       irq_mask;
  logic [dic_pkg::IRQ_W-1:0]       irq_ev;
  logic [dic_pkg::IRQ_W-1:0]       irq_clr;
  logic                            aw_got;
  logic                            w_got;
  logic [dic_pkg::ADDR_W-1:0]      aw_q;
  logic [31:0]                     wd_q;
  logic [31:0]                     wm_q;
  logic                            do_wr;
  logic                            wr_hit;
  logic [31:0]                     rd_word;
  logic                            rd_hit;

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  // a bit is accepted once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
      pin   <= 2'h0;
    end else if (ce) begin
      sync1 <= {line_fault_in, field_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= (sync2 & ~(sync2 ^ sync3)) | (pin & (sync2 ^ sync3));
    end
  end

  assign cond_in = pin[0] ^ cfg.invert; // [R7] [R15]
  assign fault   = cfg.lfd_en & pin[1]; // [R8] [R9]

  // ********************************************************
  // on and off delay
  // ********************************************************
  // rising edges wait on_dly, falling edges off_dly
  assign dly = cond_in ? on_dly : off_dly; // [R10] [R12]

  // any return to the settled level restarts the wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt <= 1'b0;
      cyc  <= '0;
      ms   <= '0;
    end else if (ce) begin
      if (cond_in == filt) begin
        cyc <= '0;
        ms  <= '0;
      end else if (ms >= dly) begin
        filt <= cond_in; // [R10] [R12]
        cyc  <= '0;
        ms   <= '0;
      end else if (cyc == CYC_LAST) begin
        cyc <= '0;
        ms  <= ms + 1'b1;
      end else begin
        cyc <= cyc + 1'b1;
      end
    end
  end

  // ********************************************************
  // error strategy and simulation
  // ********************************************************
  // last filtered value seen without a fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_val <= 1'b0;
    end else if (ce && !fault) begin
      hold_val <= filt; // [R6]
    end
  end

  always_comb begin
    next_value   = filt; // [R1]
    next_invalid = 1'b0;
    if (fault) begin
      unique case (cfg.err) // [R9]
        dic_pkg::DIC_ERR_CURRENT: begin
          next_value = filt; // [R3]
        end
        dic_pkg::DIC_ERR_SUBST: begin
          next_value   = cfg.subst; // [R4] [R13]
          next_invalid = 1'b1; // [R5]
        end
        dic_pkg::DIC_ERR_HOLD: begin
          next_value   = hold_val; // [R6]
          next_invalid = 1'b1;
        end
        default: begin
          next_value = filt;
        end
      endcase
    end
    if (cfg.mode == dic_pkg::DIC_MODE_SIM) begin
      next_value   = cfg.sim_val; // [R2] [R14] [R15]
      next_invalid = cfg.sim_bad; // [R14]
    end
    if (!module_active) begin
      next_value   = 1'b0;
      next_invalid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pv <= '0;
    end else if (ce) begin
      pv.value   <= next_value;
      pv.invalid <= next_invalid;
      pv.fault   <= fault; // [R8]
      pv.active  <= module_active; // [R11]
    end
  end

  // ********************************************************
  // interrupt status
  // ********************************************************
  always_comb begin
    irq_ev = '0;
    irq_ev[dic_pkg::IRQ_FLT_SET] = fault & ~pv.fault;
    irq_ev[dic_pkg::IRQ_FLT_CLR] = ~fault & pv.fault;
    irq_ev[dic_pkg::IRQ_VAL_CHG] = next_value ^ pv.value;
  end

  assign irq_clr = (do_wr && aw_q == dic_pkg::ADDR_IRQ_STS) ?
                   wd_q[dic_pkg::IRQ_W-1:0] & wm_q[dic_pkg::IRQ_W-1:0] : '0;

  // set beats a clear landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts <= '0;
    end else if (ce) begin
      irq_sts <= (irq_sts & ~irq_clr) | irq_ev;
    end
  end

  assign irq = |(irq_sts & irq_mask);

  // ********************************************************
  // axi4-lite write path
  // ********************************************************
  // address and data may come in either order
  assign s_axi_awready = ce & ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_got & ~s_axi_bvalid;
  assign do_wr         = ce & aw_got & w_got & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_q   <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q   <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      wd_q  <= '0;
      wm_q  <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wd_q  <= s_axi_wdata;
        wm_q  <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end else if (do_wr) begin
        w_got <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_q)
      dic_pkg::ADDR_CTRL,
      dic_pkg::ADDR_ON_DLY,
      dic_pkg::ADDR_OFF_DLY,
      dic_pkg::ADDR_STATUS,
      dic_pkg::ADDR_IRQ_STS,
      dic_pkg::ADDR_IRQ_MASK: wr_hit = 1'b1;
      default:                wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dic_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************
  // configuration registers
  // ********************************************************
  // byte lanes merge into the stored value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= dic_pkg::dic_cfg_s'(dic_pkg::CTRL_RST);
    end else if (do_wr && aw_q == dic_pkg::ADDR_CTRL) begin
      cfg <= dic_pkg::dic_cfg_s'((cfg & ~wm_q[dic_pkg::CFG_W-1:0]) |
                                 (wd_q[dic_pkg::CFG_W-1:0] & wm_q[dic_pkg::CFG_W-1:0]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_dly <= dic_pkg::DLY_RST;
    end else if (do_wr && aw_q == dic_pkg::ADDR_ON_DLY) begin
      on_dly <= (on_dly & ~wm_q[dic_pkg::DLY_W-1:0]) |
                (wd_q[dic_pkg::DLY_W-1:0] & wm_q[dic_pkg::DLY_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_dly <= dic_pkg::DLY_RST;
    end else if (do_wr && aw_q == dic_pkg::ADDR_OFF_DLY) begin
      off_dly <= (off_dly & ~wm_q[dic_pkg::DLY_W-1:0]) |
                 (wd_q[dic_pkg::DLY_W-1:0] & wm_q[dic_pkg::DLY_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= dic_pkg::IRQ_MASK_RST;
    end else if (do_wr && aw_q == dic_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= (irq_mask & ~wm_q[dic_pkg::IRQ_W-1:0]) |
                  (wd_q[dic_pkg::IRQ_W-1:0] & wm_q[dic_pkg::IRQ_W-1:0]);
    end
  end

  // ********************************************************
  // axi4-lite read path
  // ********************************************************
  assign s_axi_arready = ce & ~s_axi_rvalid;

  // status also shows the raw pin and filter output for debug
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      dic_pkg::ADDR_CTRL:     rd_word[dic_pkg::CFG_W-1:0] = cfg;
      dic_pkg::ADDR_ON_DLY:   rd_word[dic_pkg::DLY_W-1:0] = on_dly;
      dic_pkg::ADDR_OFF_DLY:  rd_word[dic_pkg::DLY_W-1:0] = off_dly;
      dic_pkg::ADDR_STATUS:   rd_word[dic_pkg::PV_W+2:0]  = {pin, filt, pv};
      dic_pkg::ADDR_IRQ_STS:  rd_word[dic_pkg::IRQ_W-1:0] = irq_sts;
      dic_pkg::ADDR_IRQ_MASK: rd_word[dic_pkg::IRQ_W-1:0] = irq_mask;
      default:                rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dic_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // dic_channel

// ===== dic_channel_checker.sv
`timescale 1ns/1ps
module dic_channel_checker #(
  parameter int unsigned P_CYC_PER_MS = dic_pkg::CYC_PER_MS
) (
  // clock, reset, settings
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             ce,
  input wire logic             module_active,
  // com unit side
  input wire dic_pkg::dic_pv_s pv,
  // bus handshakes
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_wr_resp: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_latency: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_active_follow: assert property (ce |=> pv.active == $past(module_active))
    else $error("active flag wrong");
  chk_inactive_forced: assert property (ce && !module_active |=> !pv.value && pv.invalid)
    else $error("inactive value wrong");
endmodule // dic_channel_checker

bind dic_channel dic_channel_checker #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_dic_channel_checker (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .module_active(module_active), .pv(pv),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== dic_com_model.sv
`timescale 1ns/1ps
module dic_com_model (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // channel output as collected
  input  wire dic_pkg::dic_pv_s pv,
  // edge counts of the process value
  output logic [7:0]            rises,
  output logic [7:0]            falls
);
  logic last;

  // counts every edge, so a glitch that should have been filtered shows up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last  <= 1'b0;
      rises <= 8'h00;
      falls <= 8'h00;
    end else begin
      last <= pv.value;
      if (pv.value && !last) rises <= rises + 8'h01;
      if (!pv.value && last) falls <= falls + 8'h01;
    end
  end
endmodule // dic_com_model

// ===== dic_pkg.sv
package dic_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_W         = 14;
  localparam int unsigned DLY_W         = 16;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_ON_DLY   = 8'h04;
  localparam logic [7:0]  ADDR_OFF_DLY  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_STS  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h14;

  localparam logic [7:0]  CTRL_RST      = 8'h08;
  localparam logic [15:0] DLY_RST       = 16'h0000;
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_FLT_SET   = 0;
  localparam int unsigned IRQ_FLT_CLR   = 1;
  localparam int unsigned IRQ_VAL_CHG   = 2;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic {
    DIC_MODE_NORMAL = 1'b0,
    DIC_MODE_SIM    = 1'b1
  } dic_mode_e;

  typedef enum logic [1:0] {
    DIC_ERR_CURRENT = 2'b00,
    DIC_ERR_SUBST   = 2'b01,
    DIC_ERR_HOLD    = 2'b10
  } dic_err_e;

  // control word, bit 7 down to bit 0
  typedef struct packed {
    dic_mode_e mode;
    dic_err_e  err;
    logic      invert;
    logic      lfd_en;
    logic      subst;
    logic      sim_val;
    logic      sim_bad;
  } dic_cfg_s;

  // process value toward the com unit, bit 3 down to bit 0
  typedef struct packed {
    logic value;
    logic invalid;
    logic fault;
    logic active;
  } dic_pv_s;

  localparam int unsigned CFG_W = $bits(dic_cfg_s);
  localparam int unsigned PV_W  = $bits(dic_pv_s);

endpackage

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  logic             aclk, aresetn, ce, field_in, line_fault_in, module_active, irq;
  dic_pkg::dic_pv_s pv;
  logic [7:0]       s_axi_awaddr, s_axi_araddr, rises, falls;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int               err_total, total_checks, cyc;

  // short ms keeps the delay scenarios fast
  dic_channel #(.P_CYC_PER_MS(4)) u_dic_channel (.aclk, .aresetn, .ce, .field_in, .line_fault_in,
    .module_active, .pv, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  dic_com_model u_dic_com_model (.aclk, .aresetn, .pv, .rises, .falls);

  always #50 aclk = ~aclk;

  // ********
  // tasks
  // ********
  task automatic complete_run;
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      complete_run;
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // waits a bounded time for the expected {value, invalid, fault, active}
  task automatic pv_is(input logic [3:0] e);
    int n;
    n = 0;
    while (pv !== e && n < 200) begin
      @(posedge aclk);
      n++;
    end
    check({28'h0, pv}, {28'h0, e});
  endtask

  // control word with line monitoring always on
  function automatic logic [31:0] cw(input logic m, input logic [1:0] e, input logic i, input logic s,
                                     input logic sv, input logic sb);
    return {24'h0, m, e, i, 1'b1, s, sv, sb};
  endfunction

  // ********
  // tests
  // ********
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c0;
    logic [7:0]  ra [5];
    logic [31:0] rv [5];
    ra = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    rv = '{32'h08, 32'h0, 32'h0, 32'h0, 32'h0};
    {aclk, aresetn, field_in, line_fault_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, module_active, s_axi_wstrb} = 6'h3f;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rd(ra[k], d, r);
      check(d, rv[k]);
    end
    wr(8'h18, 32'h1, r);
    check({30'h0, r}, {30'h0, dic_pkg::RESP_SLVERR});
    rd(8'h18, d, r);
    check({d[29:0], r}, {30'h0, dic_pkg::RESP_SLVERR});
    wr(dic_pkg::ADDR_STATUS, 32'hf, r);
    check({30'h0, r}, {30'h0, dic_pkg::RESP_OKAY});
    field_in <= 1'b1;
    pv_is(4'b1001);
    // status: fault pin 0, field pin 1, filtered 1, pv 1001
    rd(dic_pkg::ADDR_STATUS, d, r);
    check(d, 32'h39);
    wr(dic_pkg::ADDR_CTRL, cw(0, 2'b00, 1, 0, 0, 0), r);
    pv_is(4'b0001);
    wr(dic_pkg::ADDR_CTRL, cw(0, 2'b00, 0, 0, 0, 0), r);
    pv_is(4'b1001);
    // interrupt: raise, clear, then masked
    wr(dic_pkg::ADDR_IRQ_STS, 32'h7, r);
    wr(dic_pkg::ADDR_IRQ_MASK, 32'h1, r);
    line_fault_in <= 1'b1;
    pv_is(4'b1011);
    check({31'h0, irq}, 32'h1);
    rd(dic_pkg::ADDR_IRQ_STS, d, r);
    check(d, 32'h1);
    wr(dic_pkg::ADDR_IRQ_STS, 32'h1, r);
    check({31'h0, irq}, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(dic_pkg::ADDR_CTRL, cw(0, 2'b01, 0, s[0], 0, 0), r);
      pv_is({s[0], 3'b111});
    end
    // spare strategy code behaves as current value
    wr(dic_pkg::ADDR_CTRL, cw(0, 2'b11, 0, 0, 0, 0), r);
    pv_is(4'b1011);
    wr(dic_pkg::ADDR_CTRL, cw(0, 2'b10, 0, 0, 0, 0), r);
    field_in <= 1'b0;
    repeat (30) @(posedge aclk);
    pv_is(4'b1111);
    for (int s = 0; s < 4; s++) begin
      wr(dic_pkg::ADDR_CTRL, cw(1, 2'b00, 0, 0, s[1], s[0]), r);
      pv_is({s[1], s[0], 2'b11});
    end
    wr(dic_pkg::ADDR_IRQ_MASK, 32'h0, r);
    wr(dic_pkg::ADDR_CTRL, cw(0, 2'b00, 0, 0, 0, 0), r);
    line_fault_in <= 1'b0;
    pv_is(4'b0001);
    // value changed and fault cleared are pending, fault set was cleared
    rd(dic_pkg::ADDR_IRQ_STS, d, r);
    check({d[2:0], irq}, 32'hc);
    // delays of 2 ms against 4 cycle pulses
    wr(dic_pkg::ADDR_ON_DLY, 32'h2, r);
    wr(dic_pkg::ADDR_OFF_DLY, 32'h2, r);
    c0 = rises;
    field_in <= 1'b1;
    repeat (4) @(posedge aclk);
    field_in <= 1'b0;
    repeat (30) @(posedge aclk);
    check({24'h0, rises}, {24'h0, c0});
    field_in <= 1'b1;
    repeat (6) @(posedge aclk);
    check({31'h0, pv.value}, 32'h0);
    pv_is(4'b1001);
    c0 = falls;
    field_in <= 1'b0;
    repeat (4) @(posedge aclk);
    field_in <= 1'b1;
    repeat (30) @(posedge aclk);
    check({24'h0, falls}, {24'h0, c0});
    field_in <= 1'b0;
    repeat (6) @(posedge aclk);
    check({31'h0, pv.value}, 32'h1);
    pv_is(4'b0001);
    module_active <= 1'b0;
    pv_is(4'b0100);
    module_active <= 1'b1;
    pv_is(4'b0001);
    // clock enable low freezes the output
    ce <= 1'b0;
    module_active <= 1'b0;
    repeat (5) @(posedge aclk);
    check({28'h0, pv}, 32'h1);
    ce <= 1'b1;
    module_active <= 1'b1;
    @(posedge aclk);
    // mid-run reset restores the register defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dic_pkg::ADDR_CTRL, d, r);
    check(d, 32'h08);
    rd(dic_pkg::ADDR_OFF_DLY, d, r);
    check(d, 32'h0);
    complete_run;
  end
endmodule // tb
